// ### dv/flash_status_reset_unprotect_tb.sv
// Self-checking bench for the flash host controller with its device model.
// Assumes the design files, the checker and the model are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
`include "fsru_consts.svh"
module flash_status_reset_unprotect_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic stuck = 1'b0;
   logic suspended = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, d_oe, rst_n, vid, rbn;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, st;
   logic [18:0] fa;
   logic [7:0] dq, dout;
   int errors = 0;
   int checks = 0;
   initial
      forever
         #2.5 clk = ~clk;
   fsru_host_ctrl dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FL_CE_N(ce_n),
      .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_ADDR(fa), .FL_DATA_I(dq), .FL_DATA_O(dout),
      .FL_DATA_OE(d_oe), .FL_RESET_N(rst_n), .FL_VID_EN(vid), .FL_READY_BUSY_N(rbn));
   fsru_flash_model fm (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .din(dout),
      .din_oe(d_oe), .reset_n(rst_n), .vid_en(vid), .stuck(stuck), .suspended(suspended),
      .dq(dq), .ready_busy_n(rbn));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         ad = ad | awready;
         wd = wd | wready;
      end
      do
         @(posedge clk);
      while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(posedge clk);
      while (!arready);
      arvalid <= 1'b0;
      do
         @(posedge clk);
      while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      chk("rresp", 32'(er), 32'(rresp));
   endtask
   // Polls status until the operation ends; only the watchdog cuts a hang short.
   task automatic run_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d, input logic v);
      axi_wr(`FSRU_REG_ADDR, 32'(a), 2'h0);
      axi_wr(`FSRU_REG_DATA, 32'(d), 2'h0);
      axi_wr(`FSRU_REG_CTRL, {27'h0, v, op, 1'b1}, 2'h0);
      do
         axi_rd(`FSRU_REG_STAT, st, 2'h0);
      while (st[0] !== 1'b0);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (16)
         @(posedge clk);
      rst <= 1'b0;
      axi_rd(`FSRU_REG_STAT, st, 2'h0);
      chk("idle status", 32'h8, 32'(st[4:0]));
      axi_wr(`FSRU_REG_ADDR, 32'h7_FFFF, 2'h0);
      axi_rd(`FSRU_REG_ADDR, st, 2'h0);
      chk("addr reg", 32'h7_FFFF, st);
      axi_wr(8'h10, 32'h5, `FSRU_RESP_SLVERR);
      axi_rd(8'h10, st, `FSRU_RESP_SLVERR);
      axi_wr(`FSRU_REG_CTRL, 32'hB, 2'h0);
      axi_rd(`FSRU_REG_CTRL, st, 2'h0);
      chk("ctrl reg", 32'hA, st);
      axi_wr(`FSRU_REG_STAT, 32'hFF, 2'h0);
      axi_rd(`FSRU_REG_STAT, st, 2'h0);
      chk("bad op", 32'h4, 32'(st[2:0]));
      $display("registers done");
      run_op(`FSRU_OP_WRITE, 19'h12, 8'h5A, 1'b0);
      run_op(`FSRU_OP_DPOLL, 19'h12, 8'h5A, 1'b0);
      chk("poll result", 32'h1, 32'(st[2:1]));
      chk("poll address", 32'h12, 32'(fm.last_rd_addr));
      run_op(`FSRU_OP_READ, 19'h12, 8'h0, 1'b0);
      chk("array byte", 32'h5A, 32'(st[15:8]));
      run_op(`FSRU_OP_WRITE, 19'h21, 8'hC3, 1'b0);
      run_op(`FSRU_OP_TPOLL, 19'h1_0000, 8'h0, 1'b0);
      chk("toggle result", 32'h1, 32'(st[2:1]));
      $display("polling done");
      stuck <= 1'b1;
      run_op(`FSRU_OP_WRITE, 19'h30, 8'h0F, 1'b0);
      run_op(`FSRU_OP_DPOLL, 19'h30, 8'h0F, 1'b0);
      chk("limit poll", 32'h2, 32'(st[2:1]));
      run_op(`FSRU_OP_TPOLL, 19'h30, 8'h0, 1'b0);
      chk("limit toggle", 32'h2, 32'(st[2:1]));
      run_op(`FSRU_OP_RESET, 19'h0, 8'h0, 1'b0);
      stuck <= 1'b0;
      chk("ready after abort", 32'h1, 32'(st[3]));
      run_op(`FSRU_OP_RESET, 19'h0, 8'h0, 1'b0);
      run_op(`FSRU_OP_READ, 19'h12, 8'h0, 1'b0);
      chk("read after reset", 32'h5A, 32'(st[15:8]));
      $display("reset done");
      run_op(`FSRU_OP_WRITE, 19'h7_0005, 8'h11, 1'b0);
      run_op(`FSRU_OP_READ, 19'h7_0005, 8'h0, 1'b0);
      chk("protected byte", 32'hFF, 32'(st[15:8]));
      run_op(`FSRU_OP_WRITE, 19'h7_0005, 8'h22, 1'b1);
      run_op(`FSRU_OP_DPOLL, 19'h7_0005, 8'h22, 1'b1);
      chk("vid poll", 32'h1, 32'(st[2:1]));
      run_op(`FSRU_OP_READ, 19'h7_0005, 8'h0, 1'b0);
      chk("unprotected byte", 32'h22, 32'(st[15:8]));
      run_op(`FSRU_OP_WRITE, 19'h7_0006, 8'h33, 1'b0);
      run_op(`FSRU_OP_READ, 19'h7_0006, 8'h0, 1'b0);
      chk("reprotected byte", 32'hFF, 32'(st[15:8]));
      $display("unprotect done");
      suspended <= 1'b1;
      run_op(`FSRU_OP_TPOLL, 19'h5_0001, 8'h0, 1'b0);
      chk("suspend toggle", 32'h1, 32'(st[5]));
      run_op(`FSRU_OP_TPOLL, 19'h1_0001, 8'h0, 1'b0);
      chk("no suspend toggle", 32'h0, 32'(st[5]));
      $display("suspend done");
      wrap_up();
   end
   initial
   begin
      repeat (80000)
         @(posedge clk);
      errors++;
      wrap_up();
   end
endmodule
bind fsru_host_ctrl fsru_props chk_i (.CLK(CLK), .RST(RST), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
   .FL_ADDR(FL_ADDR), .FL_DATA_OE(FL_DATA_OE), .FL_RESET_N(FL_RESET_N), .FL_VID_EN(FL_VID_EN));
`default_nettype wire

// ### dv/fsru_flash_model.sv
// Behavioural flash device answering the host controller's pins.
// Assumes the bench clock to sample its write and read strobes and to time its embedded algorithm.
`timescale 1ns/1ps
`default_nettype none
module fsru_flash_model
#(
   parameter int BUSY_CYC = 200,
   parameter logic [2:0] PROT_SEC = 3'h7,
   parameter logic [2:0] SUSP_SEC = 3'h5
)
(
   // Timing clock
   input wire logic clk,
   // Host pins
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [18:0] addr,
   input wire logic [7:0] din,
   input wire logic din_oe,
   input wire logic reset_n,
   input wire logic vid_en,
   // Fault controls
   input wire logic stuck,
   input wire logic suspended,
   // Device outputs
   output logic [7:0] dq,
   output logic ready_busy_n
);
   logic [7:0] mem [256];
   logic [7:0] pd = 8'h0;
   logic [7:0] rd;
   logic [18:0] pa = 19'h0;
   logic [18:0] last_rd_addr = 19'h0;
   logic busy = 1'b0;
   logic limit = 1'b0;
   logic tog = 1'b0;
   logic stog = 1'b0;
   logic rd_q = 1'b0;
   logic we_q = 1'b1;
   logic in_susp;
   int cnt = 0;
   initial
      foreach (mem[i])
         mem[i] = 8'hFF;
   assign in_susp = suspended && addr[18:16] == SUSP_SEC;
   always @(posedge clk)
   begin
      rd_q <= !ce_n && !oe_n;
      we_q <= we_n;
      if (!reset_n)
      begin
         busy <= 1'b0;
         limit <= 1'b0;
      end
      else if (!we_q && we_n && din_oe && (addr[18:16] != PROT_SEC || vid_en))
      begin
         busy <= 1'b1;
         cnt <= 0;
         pa <= addr;
         pd <= din;
         mem[addr[7:0]] <= din;
      end
      else if (busy && cnt < BUSY_CYC)
         cnt <= cnt + 1;
      else if (busy)
      begin
         limit <= stuck;
         busy <= stuck;
      end
      if (!rd_q && !ce_n && !oe_n)
      begin
         tog <= tog ^ busy;
         stog <= stog ^ in_susp;
         last_rd_addr <= addr;
      end
   end
   // A wrong poll address shows a false match, so a host that polls elsewhere is caught.
   assign rd = (busy || in_susp) ? {(addr == pa) ^ pd[7], tog, limit, 2'b00, stog, 2'b00} : mem[addr[7:0]];
   // A released bus shows the inverse value, so a late sample cannot pass by luck.
   assign dq = din_oe ? din : (!ce_n && !oe_n) ? rd : ~rd;
   assign ready_busy_n = !busy;
endmodule
`default_nettype wire

// ### dv/fsru_props.sv
// Checker for the flash pins and the response channel of the host controller.
// Assumes it is bound to fsru_host_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fsru_props
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Register port
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // Flash pins
   input wire logic FL_CE_N,
   input wire logic FL_OE_N,
   input wire logic FL_WE_N,
   input wire logic [18:0] FL_ADDR,
   input wire logic FL_DATA_OE,
   input wire logic FL_RESET_N,
   input wire logic FL_VID_EN
);
   int rst_lo, since_rst, vid_hi, oe_lo;
   // The since_rst and vid_hi counters saturate, so a long idle span can never wrap them into a false pass.
   always_ff @(posedge CLK)
   begin
      rst_lo <= (RST || FL_RESET_N) ? 0 : rst_lo + 1;
      since_rst <= RST ? 1000 : !FL_RESET_N ? 0 : (since_rst < 1000) ? since_rst + 1 : 1000;
      vid_hi <= (RST || !FL_VID_EN) ? 0 : (vid_hi < 2000) ? vid_hi + 1 : 2000;
      oe_lo <= (RST || FL_OE_N) ? 0 : oe_lo + 1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   rst_width_a: assert property ($rose(FL_RESET_N) |-> rst_lo >= 100) else $error("reset pulse short");
   rst_recover_a: assert property ($fell(FL_OE_N) |-> since_rst >= 10) else $error("read too soon");
   vid_setup_a: assert property ($fell(FL_WE_N) && FL_VID_EN |-> vid_hi >= 800) else $error("vid write early");
   read_pair_a: assert property ($fell(FL_OE_N) |-> $fell(FL_CE_N)) else $error("read not paired");
   read_len_a: assert property ($rose(FL_OE_N) |-> oe_lo >= 14) else $error("read too short");
   addr_hold_a: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR)) else $error("address moved");
   no_clash_a: assert property (!FL_OE_N |-> FL_WE_N && !FL_DATA_OE) else $error("bus clash");
   wr_pulse_a: assert property ($fell(FL_WE_N) |-> (!FL_WE_N && FL_DATA_OE) [*7]) else $error("write short");
   b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
   b_clear_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid repeated");
   cover property ($rose(FL_RESET_N));
   cover property ($fell(FL_WE_N) && FL_VID_EN);
   cover property ($rose(FL_OE_N) && FL_VID_EN);
endmodule
`default_nettype wire

// ### hdl/fsru_consts.svh
// Named constants for the flash status, reset and unprotect host controller.
// Assumes a 200 MHz CLK; every time below is in nanoseconds except FSRU_SYNC_LAT, which is in CLK cycles.
`ifndef FSRU_CONSTS_SVH
`define FSRU_CONSTS_SVH
`define FSRU_CLK_NS 5
`define FSRU_T_RP_NS 500
`define FSRU_T_RH_NS 50
`define FSRU_T_RSP_NS 4000
`define FSRU_T_ACC_NS 70
`define FSRU_T_WP_NS 35
`define FSRU_T_WPH_NS 30
`define FSRU_SYNC_LAT 3
`define FSRU_REG_CTRL 8'h00
`define FSRU_REG_ADDR 8'h04
`define FSRU_REG_DATA 8'h08
`define FSRU_REG_STAT 8'h0C
`define FSRU_OP_READ 3'h0
`define FSRU_OP_WRITE 3'h1
`define FSRU_OP_DPOLL 3'h2
`define FSRU_OP_TPOLL 3'h3
`define FSRU_OP_RESET 3'h4
`define FSRU_RES_NONE 2'h0
`define FSRU_RES_PASS 2'h1
`define FSRU_RES_FAIL 2'h2
`define FSRU_RESP_OKAY 2'h0
`define FSRU_RESP_SLVERR 2'h2
`define FSRU_BIT_POLL 7
`define FSRU_BIT_TOGGLE 6
`define FSRU_BIT_LIMIT 5
`define FSRU_BIT_SUSPEND 2
`endif

// ### hdl/fsru_host_ctrl.sv
// Host controller that drives a parallel NOR flash and polls its status.
// Assumes an AXI4-Lite master on CLK and a flash wired to the FL_ pins.
// Behaviour
// - Recheck poll bit after time-limit flag rises
// - Two consecutive reads decide toggling
// - Recheck toggle bit after time-limit flag rises
// - Every chip or output pulse is new read
// - Poll reads use programmed or erased address
// - Hold reset low at least 500 ns
// - Wait 50 ns after reset before reading
// - Reading may start right when ready shows
// - Wait 4 us after high voltage before writing
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fsru_consts.svh"
module fsru_host_ctrl
   import fsru_pkg::*;
#(
   parameter int T_ACC_NS = `FSRU_T_ACC_NS,
   parameter int T_RSP_NS = `FSRU_T_RSP_NS
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // AXI4-Lite register port
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Flash pins
   output logic FL_CE_N,
   output logic FL_OE_N,
   output logic FL_WE_N,
   output logic [18:0] FL_ADDR,
   input wire logic [7:0] FL_DATA_I,
   output logic [7:0] FL_DATA_O,
   output logic FL_DATA_OE,
   output logic FL_RESET_N,
   output logic FL_VID_EN,
   input wire logic FL_READY_BUSY_N
);

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + `FSRU_CLK_NS - 1) / `FSRU_CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Read access includes the pin synchroniser so the sampled byte is settled.
   localparam logic [15:0] ACC_C = 16'(cyc_up(T_ACC_NS) + `FSRU_SYNC_LAT);
   localparam logic [15:0] WP_C = 16'(cyc_up(`FSRU_T_WP_NS));
   localparam logic [15:0] WPH_C = 16'(cyc_up(`FSRU_T_WPH_NS));
   localparam logic [15:0] RP_C = 16'(cyc_up(`FSRU_T_RP_NS));
   localparam logic [15:0] RH_C = 16'(cyc_up(`FSRU_T_RH_NS));
   localparam logic [15:0] RSP_C = 16'(cyc_up(T_RSP_NS));

   logic [7:0] aw_addr, next_aw_addr;
   logic aw_full, next_aw_full;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic w_full, next_w_full;
   logic awready, next_awready, wready, next_wready, arready, next_arready;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic vid_en, next_vid_en, vid_ready, next_vid_ready;
   logic [15:0] vid_cnt, next_vid_cnt;
   logic [2:0] op, next_op;
   logic [18:0] addr, next_addr;
   logic [7:0] data, next_data;
   fsru_state_e state, next_state;
   logic [15:0] cnt, next_cnt;
   logic [1:0] step, next_step, result, next_result;
   logic [7:0] rd_val, next_rd_val, prev_val, next_prev_val;
   logic sus_tog, next_sus_tog;
   logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n, rst_n, next_rst_n;
   logic [18:0] fl_addr, next_fl_addr;
   logic [7:0] dq_o, next_dq_o;
   logic dq_oe, next_dq_oe;
   logic [2:0] rb_s;
   logic [7:0] dq_s [3];
   logic rb_level, next_rb_level;
   logic start;

   always_comb
   begin
      logic [31:0] ctrl_w;
      logic [31:0] reg_r;
      ctrl_w = 32'h0000_0000;
      reg_r = 32'h0000_0000;
      next_aw_addr = aw_addr;
      next_aw_full = aw_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_w_full = w_full;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_vid_en = vid_en;
      next_op = op;
      next_addr = addr;
      next_data = data;
      start = 1'b0;
      next_rb_level = (rb_s[1] == rb_s[2]) ? rb_s[2] : rb_level;
      if (S_AXI_AWVALID && awready)
      begin
         next_aw_addr = S_AXI_AWADDR;
         next_aw_full = 1'b1;
      end
      if (S_AXI_WVALID && wready)
      begin
         next_w_data = S_AXI_WDATA;
         next_w_strb = S_AXI_WSTRB;
         next_w_full = 1'b1;
      end
      if (bvalid && S_AXI_BREADY)
      begin
         next_bvalid = 1'b0;
      end
      else if (aw_full && w_full && !bvalid)
      begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `FSRU_RESP_OKAY;
         if (aw_addr == `FSRU_REG_CTRL)
         begin
            ctrl_w = merge({27'h000_0000, vid_en, op, 1'b0}, w_data, w_strb);
            next_vid_en = ctrl_w[4];
            next_op = ctrl_w[3:1];
            start = ctrl_w[0];
         end
         else if (aw_addr == `FSRU_REG_ADDR)
         begin
            next_addr = 19'(merge({13'h0000, addr}, w_data, w_strb));
         end
         else if (aw_addr == `FSRU_REG_DATA)
         begin
            next_data = 8'(merge({24'h00_0000, data}, w_data, w_strb));
         end
         else if (aw_addr != `FSRU_REG_STAT)
         begin
            next_bresp = `FSRU_RESP_SLVERR;
         end
      end
      if (rvalid && S_AXI_RREADY)
      begin
         next_rvalid = 1'b0;
      end
      else if (S_AXI_ARVALID && arready)
      begin
         next_rvalid = 1'b1;
         next_rresp = `FSRU_RESP_OKAY;
         if (S_AXI_ARADDR == `FSRU_REG_CTRL)
         begin
            reg_r = {27'h000_0000, vid_en, op, 1'b0};
         end
         else if (S_AXI_ARADDR == `FSRU_REG_ADDR)
         begin
            reg_r = {13'h0000, addr};
         end
         else if (S_AXI_ARADDR == `FSRU_REG_DATA)
         begin
            reg_r = {24'h00_0000, data};
         end
         else if (S_AXI_ARADDR == `FSRU_REG_STAT)
         begin
            reg_r = {16'h0000, rd_val, 2'h0, sus_tog, vid_ready, rb_level, result, state != S_IDLE};
         end
         else
         begin
            next_rresp = `FSRU_RESP_SLVERR;
         end
         next_rdata = reg_r;
      end
      next_awready = !next_aw_full && !next_bvalid;
      next_wready = !next_w_full && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // Write cycles in unprotect mode are held back until the raised reset level has settled.
   always_comb
   begin
      next_vid_cnt = vid_cnt;
      next_vid_ready = vid_ready;
      if (!vid_en)
      begin
         next_vid_cnt = RSP_C;
         next_vid_ready = 1'b0;
      end
      else if (vid_cnt != 16'h0000)
      begin
         next_vid_cnt = vid_cnt - 16'h0001;
      end
      else
      begin
         next_vid_ready = 1'b1;
      end
   end

   always_comb
   begin
      logic another;
      another = 1'b0;
      next_state = state;
      next_cnt = cnt;
      next_step = step;
      next_result = result;
      next_rd_val = rd_val;
      next_prev_val = prev_val;
      next_sus_tog = sus_tog;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_rst_n = rst_n;
      next_fl_addr = fl_addr;
      next_dq_o = dq_o;
      next_dq_oe = dq_oe;
      case (state)
         S_IDLE:
         begin
            // A start while busy is dropped; software checks the busy bit first.
            if (start)
            begin
               next_fl_addr = addr;
               next_step = 2'h0;
               next_sus_tog = 1'b0;
               next_result = `FSRU_RES_NONE;
               if (next_op == `FSRU_OP_WRITE)
               begin
                  next_state = S_WR_SETUP;
               end
               else if (next_op == `FSRU_OP_RESET)
               begin
                  next_rst_n = 1'b0;
                  next_cnt = RP_C;
                  next_state = S_RST_LOW;
               end
               else if (next_op <= `FSRU_OP_TPOLL)
               begin
                  another = 1'b1;
               end
               else
               begin
                  next_result = `FSRU_RES_FAIL;
               end
            end
         end
         S_RD_ACC:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else if (dq_s[1] == dq_s[2])
            begin
               next_rd_val = dq_s[2];
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_cnt = WPH_C;
               next_state = S_RD_GAP;
            end
         end
         S_RD_GAP:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else
            begin
               next_state = S_EVAL;
            end
         end
         S_EVAL:
         begin
            next_state = S_IDLE;
            next_prev_val = rd_val;
            if (op == `FSRU_OP_READ)
            begin
               next_result = `FSRU_RES_PASS;
            end
            else if (op == `FSRU_OP_DPOLL)
            begin
               if (rd_val[`FSRU_BIT_POLL] == data[`FSRU_BIT_POLL])
               begin
                  next_result = `FSRU_RES_PASS;
               end
               else if (step != 2'h0)
               begin
                  next_result = `FSRU_RES_FAIL;
               end
               else
               begin
                  next_step = rd_val[`FSRU_BIT_LIMIT] ? 2'h1 : 2'h0;
                  another = 1'b1;
               end
            end
            else
            begin
               if (step != 2'h0 && rd_val[`FSRU_BIT_SUSPEND] != prev_val[`FSRU_BIT_SUSPEND])
               begin
                  next_sus_tog = 1'b1;
               end
               if (step == 2'h0 || step == 2'h2)
               begin
                  next_step = step + 2'h1;
                  another = 1'b1;
               end
               else if (rd_val[`FSRU_BIT_TOGGLE] == prev_val[`FSRU_BIT_TOGGLE])
               begin
                  next_result = `FSRU_RES_PASS;
               end
               else if (step == 2'h3)
               begin
                  next_result = `FSRU_RES_FAIL;
               end
               else if (rd_val[`FSRU_BIT_LIMIT])
               begin
                  next_step = 2'h2;
                  another = 1'b1;
               end
               else
               begin
                  another = 1'b1;
               end
            end
         end
         S_WR_SETUP:
         begin
            if (!vid_en || vid_ready)
            begin
               next_dq_o = data;
               next_dq_oe = 1'b1;
               next_ce_n = 1'b0;
               next_we_n = 1'b0;
               next_cnt = WP_C;
               next_state = S_WR_PULSE;
            end
         end
         S_WR_PULSE:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else
            begin
               next_we_n = 1'b1;
               next_ce_n = 1'b1;
               next_cnt = WPH_C;
               next_state = S_WR_GAP;
            end
         end
         S_WR_GAP:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else
            begin
               next_dq_oe = 1'b0;
               next_result = `FSRU_RES_PASS;
               next_state = S_IDLE;
            end
         end
         S_RST_LOW:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else
            begin
               next_rst_n = 1'b1;
               next_cnt = RH_C;
               next_state = S_RST_HIGH;
            end
         end
         S_RST_HIGH:
         begin
            if (cnt != 16'h0000)
            begin
               next_cnt = cnt - 16'h0001;
            end
            else
            begin
               next_result = `FSRU_RES_PASS;
               next_state = S_IDLE;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
      if (another)
      begin
         // Each status read is its own chip and output enable pulse.
         next_ce_n = 1'b0;
         next_oe_n = 1'b0;
         next_cnt = ACC_C;
         next_state = S_RD_ACC;
      end
   end

   always_ff @(posedge CLK)
   begin
      rb_s <= {rb_s[1:0], FL_READY_BUSY_N};
      dq_s[0] <= FL_DATA_I;
      dq_s[1] <= dq_s[0];
      dq_s[2] <= dq_s[1];
      if (RST)
      begin
         aw_addr <= 8'h00;
         aw_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         w_full <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `FSRU_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `FSRU_RESP_OKAY;
         rdata <= 32'h0000_0000;
         vid_en <= 1'b0;
         vid_ready <= 1'b0;
         vid_cnt <= 16'h0000;
         op <= `FSRU_OP_READ;
         addr <= 19'h0_0000;
         data <= 8'h00;
         state <= S_IDLE;
         cnt <= 16'h0000;
         step <= 2'h0;
         result <= `FSRU_RES_NONE;
         rd_val <= 8'h00;
         prev_val <= 8'h00;
         sus_tog <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         rst_n <= 1'b1;
         fl_addr <= 19'h0_0000;
         dq_o <= 8'h00;
         dq_oe <= 1'b0;
         rb_level <= 1'b1;
      end
      else
      begin
         aw_addr <= next_aw_addr;
         aw_full <= next_aw_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         w_full <= next_w_full;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         vid_en <= next_vid_en;
         vid_ready <= next_vid_ready;
         vid_cnt <= next_vid_cnt;
         op <= next_op;
         addr <= next_addr;
         data <= next_data;
         state <= next_state;
         cnt <= next_cnt;
         step <= next_step;
         result <= next_result;
         rd_val <= next_rd_val;
         prev_val <= next_prev_val;
         sus_tog <= next_sus_tog;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         rst_n <= next_rst_n;
         fl_addr <= next_fl_addr;
         dq_o <= next_dq_o;
         dq_oe <= next_dq_oe;
         rb_level <= next_rb_level;
      end
   end

   assign S_AXI_AWREADY = awready;
   assign S_AXI_WREADY = wready;
   assign S_AXI_BVALID = bvalid;
   assign S_AXI_BRESP = bresp;
   assign S_AXI_ARREADY = arready;
   assign S_AXI_RVALID = rvalid;
   assign S_AXI_RRESP = rresp;
   assign S_AXI_RDATA = rdata;
   assign FL_CE_N = ce_n;
   assign FL_OE_N = oe_n;
   assign FL_WE_N = we_n;
   assign FL_ADDR = fl_addr;
   assign FL_DATA_O = dq_o;
   assign FL_DATA_OE = dq_oe;
   assign FL_RESET_N = rst_n;
   assign FL_VID_EN = vid_en;
endmodule
`default_nettype wire

// ### hdl/fsru_pkg.sv
// Types shared by the flash status, reset and unprotect host controller.
// Assumes nothing of its surroundings.
`default_nettype none
package fsru_pkg;
   typedef enum logic [3:0]
   {
      S_IDLE, S_RD_ACC, S_RD_GAP, S_EVAL, S_WR_SETUP, S_WR_PULSE, S_WR_GAP, S_RST_LOW, S_RST_HIGH
   } fsru_state_e;
endpackage
`default_nettype wire
